//--- src/rwake_top.sv
`timescale 1ns/1ps
`include "rwake_defines.svh"

module rwake_top #(
    parameter int ADDR_W = 8,
    parameter int NPINS  = 11
) (
    // Clock and reset
    input  wire logic              pclk,
    input  wire logic              presetn,
    // APB slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic [31:0]            prdata,
    output logic                   pready,
    output logic                   pslverr,
    // MAC wake events, same clock
    input  wire logic              mac_unicast_evt,
    input  wire logic              mac_magic_evt,
    input  wire logic              mac_pattern_evt,
    input  wire logic              mac_exact_dest_evt,
    input  wire logic              mac_bcast_evt,
    input  wire logic              mac_good_frame_evt,
    // PHY events, asynchronous
    input  wire logic              phy_interrupt,
    input  wire logic              phy_link_up,
    // General-purpose pins, asynchronous
    input  wire logic [NPINS-1:0]  pin_level,
    // USB side, same clock
    input  wire logic              usb_suspend,
    input  wire logic              host_resume,
    // Results
    output logic                   remote_wake,
    output logic                   wake_interrupt,
    output logic                   phy_energy_powerdown,
    output logic                   suspended
);

    // Elaboration check: the pin map and decoder serve only these sizes
    if (NPINS != 11 || ADDR_W < 8) begin : g_param_check
        $error("rwake_top: pin count must be 11 and address width at least 8");
    end

    // Register state
    logic [1:0]       wake_status_bits_reg;
    logic             energy_wake_enable_reg;
    logic             lan_wake_enable_reg;
    rwake_pkg::rwake_susp_e susp_sel_reg;
    logic [4:0]       mac_en_reg;
    logic [3:0]       mac_rcv_reg;
    logic [7:0]       pin_wake_enable_low_reg;
    logic [5:0]       pin_function_select_reg;
    logic [2:0]       pin_direction_reg;
    logic [NPINS-1:0] pin_wake_enable_reg;
    logic [NPINS-1:0] pin_wake_polarity_reg;
    logic             link_up_on_pin7_enable_reg;
    logic [NPINS-1:0] pin_event_flag_reg;
    logic             internal_phy_mode_reg;
    logic             energy_powerdown_control_reg;
    rwake_pkg::rwake_state_e st_reg;
    rwake_pkg::rwake_state_e st_next;
    logic             usb_suspend_d_reg;
    logic             remote_wake_reg;
    logic             wake_int_reg;
    logic [31:0]      prdata_reg;

    logic [NPINS-1:0] pin_s1_reg;
    logic [NPINS-1:0] pin_s2_reg;
    logic [1:0]       phy_s1_reg;
    logic [1:0]       phy_s2_reg;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_s1_reg <= '0;
            pin_s2_reg <= '0;
            phy_s1_reg <= 2'h0;
            phy_s2_reg <= 2'h0;
        end else begin
            pin_s1_reg <= pin_level;
            pin_s2_reg <= pin_s1_reg;
            phy_s1_reg <= {phy_link_up, phy_interrupt};
            phy_s2_reg <= phy_s1_reg;
        end
    end
    wire phy_int_s  = phy_s2_reg[0];
    wire phy_link_s = phy_s2_reg[1];

    // APB decode; the slave never stalls, so pready stays high
    wire [7:0] addr8   = paddr[7:0];
    wire hit_pmr   = (addr8 == `RW_PMR_OFF);
    wire hit_mwc   = (addr8 == `RW_MWC_OFF);
    wire hit_pcfg  = (addr8 == `RW_PCFG_OFF);
    wire hit_lcfg  = (addr8 == `RW_LCFG_OFF);
    wire hit_pwake = (addr8 == `RW_PWAKE_OFF);
    wire hit_ists  = (addr8 == `RW_ISTS_OFF);
    wire hit_ctrl  = (addr8 == `RW_CTRL_OFF);
    wire addr_ok   = ((paddr >> 8) == '0) &&
                     (hit_pmr | hit_mwc | hit_pcfg | hit_lcfg | hit_pwake | hit_ists | hit_ctrl);
    wire access    = psel & penable;
    wire wr        = access & pwrite & addr_ok;
    wire rd_setup  = psel & ~penable & ~pwrite;
    assign pready  = 1'b1;
    assign pslverr = access & ~addr_ok;

    // State qualifiers
    wire in_susp  = (st_reg == rwake_pkg::RWAKE_SUSPENDED);
    wire s_zero   = in_susp & (susp_sel_reg == rwake_pkg::RWAKE_SUSP_ZERO);
    wire s_one    = in_susp & (susp_sel_reg == rwake_pkg::RWAKE_SUSP_ONE);
    wire s_three  = in_susp & (susp_sel_reg == rwake_pkg::RWAKE_SUSP_THREE);

    wire [4:0] mac_evt = {mac_bcast_evt, mac_exact_dest_evt, mac_pattern_evt,
                          mac_magic_evt, mac_unicast_evt};
    wire [4:0] mac_gated = mac_evt & mac_en_reg;
    wire mac_comp = |mac_gated;
    // good frame counts only with every MAC enable clear
    wire good_frame = mac_good_frame_evt & ~(|mac_en_reg);

    wire lan_int    = lan_wake_enable_reg & mac_comp;
    wire energy_int = energy_wake_enable_reg & phy_int_s;
    wire wake_int   = lan_int | energy_int | good_frame;

    // status set terms; live events also hold the bits
    wire [1:0] stat_set = {mac_comp | good_frame, phy_int_s};
    wire [1:0] stat_clr = (wr & hit_pmr) ? pwdata[`RW_PMR_STAT_MSB:`RW_PMR_STAT_LSB] : 2'h0;
    wire [1:0] stat_next = stat_set | (wake_status_bits_reg & ~stat_clr);

    // received-source bits, write one to clear, set wins
    wire [3:0] rcv_set = {mac_gated[`RW_SRC_BCAST], mac_gated[`RW_SRC_EXACT],
                          mac_gated[`RW_SRC_MAGIC], mac_gated[`RW_SRC_PATTERN]};
    wire [3:0] rcv_clr = (wr & hit_mwc) ? pwdata[`RW_MWC_RCV_MSB:`RW_MWC_RCV_LSB] : 4'h0;
    wire [3:0] rcv_next = rcv_set | (mac_rcv_reg & ~rcv_clr);

    // pins 8 to 10 enabled by input programming
    logic [2:0] hi_input;
    genvar gi;
    for (gi = 0; gi < 3; gi++) begin : g_hi
        assign hi_input[gi] = (pin_function_select_reg[2*gi+1:2*gi] == `RW_FS_INPUT) &
                              ~pin_direction_reg[gi];
    end
    // low pins need internal PHY mode; low enable is active when zero
    wire [NPINS-1:0] pin_en_path = {hi_input, ~pin_wake_enable_low_reg & {8{internal_phy_mode_reg}}};

    // link-up replaces pin 7 level whenever enabled; it matches only in states zero and three
    wire link7_mode = link_up_on_pin7_enable_reg & (s_zero | s_three);
    logic [NPINS-1:0] pin_match;
    always_comb begin
        pin_match = ~(pin_s2_reg ^ pin_wake_polarity_reg);
        if (link_up_on_pin7_enable_reg) begin
            pin_match[`RW_PIN7] = link7_mode & phy_link_s;
        end
    end
    // hit needs enable, path enable and matching level
    wire [NPINS-1:0] pin_hit = pin_match & pin_wake_enable_reg & pin_en_path;

    // pin flags set by hits, write one to clear, set wins
    wire [NPINS-1:0] pin_clr = (wr & hit_ists) ? pwdata[NPINS-1:0] : '0;
    wire [NPINS-1:0] pin_flag_next = pin_hit | (pin_event_flag_reg & ~pin_clr);

    // LAN wake only in state zero; held status wakes once enabled
    wire lan_wake = s_zero & lan_wake_enable_reg & wake_status_bits_reg[1] & (|mac_en_reg);
    // energy wake only in state one; held status wakes once enabled
    wire ed_wake = s_one & energy_wake_enable_reg & wake_status_bits_reg[0];
    // good frame wake only in state three
    wire good_wake = s_three & wake_status_bits_reg[1] & ~(|mac_en_reg);
    // pin flags wake in any suspend state
    wire pin_wake = in_susp & (|pin_event_flag_reg);
    wire wake_any = lan_wake | ed_wake | good_wake | pin_wake;

    // Suspend entered on the rising edge of USB suspend signalling
    always_comb begin
        st_next = st_reg;
        case (st_reg)
            rwake_pkg::RWAKE_NORMAL: begin
                if (usb_suspend & ~usb_suspend_d_reg) begin
                    st_next = rwake_pkg::RWAKE_SUSPENDED;
                end
            end
            rwake_pkg::RWAKE_SUSPENDED: begin
                // any enabled wake returns to normal
                if (wake_any | host_resume) begin
                    st_next = rwake_pkg::RWAKE_NORMAL;
                end
            end
            default: st_next = rwake_pkg::RWAKE_NORMAL;
        endcase
    end

    // State, wake request and interrupt
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg            <= rwake_pkg::RWAKE_NORMAL;
            usb_suspend_d_reg <= 1'b0;
            remote_wake_reg   <= 1'b0;
            wake_int_reg      <= 1'b0;
        end else begin
            st_reg            <= st_next;
            usb_suspend_d_reg <= usb_suspend;
            // request raised with the wake that ends suspend
            remote_wake_reg   <= in_susp & wake_any;
            wake_int_reg      <= wake_int;
        end
    end

    // Status registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wake_status_bits_reg <= 2'h0;
            mac_rcv_reg          <= 4'h0;
            pin_event_flag_reg   <= '0;
        end else begin
            wake_status_bits_reg <= stat_next;
            mac_rcv_reg          <= rcv_next;
            pin_event_flag_reg   <= pin_flag_next;
        end
    end

    // Control registers written over APB
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            energy_wake_enable_reg       <= 1'b0;
            lan_wake_enable_reg          <= 1'b0;
            // state two is the default selection
            susp_sel_reg                 <= rwake_pkg::RWAKE_SUSP_TWO;
            mac_en_reg                   <= 5'h0;
            pin_wake_enable_low_reg      <= `RW_LOW_EN_RST;
            pin_function_select_reg      <= `RW_LCFG_FS_RST;
            pin_direction_reg            <= `RW_LCFG_DIR_RST;
            pin_wake_enable_reg          <= '0;
            pin_wake_polarity_reg        <= '0;
            link_up_on_pin7_enable_reg   <= 1'b0;
            internal_phy_mode_reg        <= 1'b1;
            energy_powerdown_control_reg <= 1'b0;
        end else if (wr) begin
            if (hit_pmr) begin
                energy_wake_enable_reg <= pwdata[`RW_PMR_ENERGY_WAKE_ENABLE];
                lan_wake_enable_reg    <= pwdata[`RW_PMR_LAN_EN];
                susp_sel_reg           <= rwake_pkg::rwake_susp_e'(pwdata[`RW_PMR_SUSP_MSB:`RW_PMR_SUSP_LSB]);
            end
            if (hit_mwc) begin
                mac_en_reg <= pwdata[`RW_MWC_EN_MSB:`RW_MWC_EN_LSB];
            end
            if (hit_pcfg) begin
                pin_wake_enable_low_reg <= pwdata[7:0];
            end
            if (hit_lcfg) begin
                pin_function_select_reg <= pwdata[`RW_LC_FS_MSB:`RW_LC_FS_LSB];
                pin_direction_reg       <= pwdata[`RW_LC_DIR_MSB:`RW_LC_DIR_LSB];
            end
            if (hit_pwake) begin
                pin_wake_enable_reg        <= pwdata[`RW_PW_EN_MSB:`RW_PW_EN_LSB];
                pin_wake_polarity_reg      <= pwdata[`RW_PW_POL_MSB:`RW_PW_POL_LSB];
                link_up_on_pin7_enable_reg <= pwdata[`RW_PW_LINK7];
            end
            if (hit_ctrl) begin
                internal_phy_mode_reg        <= pwdata[`RW_CTRL_INT_PHY];
                energy_powerdown_control_reg <= pwdata[`RW_CTRL_EDPD];
            end
        end
    end

    // Read mux, captured in the setup cycle so prdata is a flop
    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h0;
        if (hit_pmr) begin
            rd_mux[`RW_PMR_STAT_MSB:`RW_PMR_STAT_LSB] = wake_status_bits_reg;
            rd_mux[`RW_PMR_ENERGY_WAKE_ENABLE]     = energy_wake_enable_reg;
            rd_mux[`RW_PMR_LAN_EN]    = lan_wake_enable_reg;
            rd_mux[`RW_PMR_SUSP_MSB:`RW_PMR_SUSP_LSB] = susp_sel_reg;
            rd_mux[`RW_PMR_SUSPENDED] = in_susp;
            rd_mux[`RW_PMR_WAKE_INT]  = wake_int_reg;
        end
        if (hit_mwc) begin
            rd_mux[`RW_MWC_EN_MSB:`RW_MWC_EN_LSB]   = mac_en_reg;
            rd_mux[`RW_MWC_RCV_MSB:`RW_MWC_RCV_LSB] = mac_rcv_reg;
        end
        if (hit_pcfg) begin
            rd_mux[7:0] = pin_wake_enable_low_reg;
        end
        if (hit_lcfg) begin
            rd_mux[`RW_LC_FS_MSB:`RW_LC_FS_LSB]   = pin_function_select_reg;
            rd_mux[`RW_LC_DIR_MSB:`RW_LC_DIR_LSB] = pin_direction_reg;
        end
        if (hit_pwake) begin
            rd_mux[`RW_PW_EN_MSB:`RW_PW_EN_LSB]   = pin_wake_enable_reg;
            rd_mux[`RW_PW_POL_MSB:`RW_PW_POL_LSB] = pin_wake_polarity_reg;
            rd_mux[`RW_PW_LINK7]                  = link_up_on_pin7_enable_reg;
        end
        if (hit_ists) begin
            rd_mux[NPINS-1:0] = pin_event_flag_reg;
        end
        if (hit_ctrl) begin
            rd_mux[`RW_CTRL_INT_PHY] = internal_phy_mode_reg;
            rd_mux[`RW_CTRL_EDPD]    = energy_powerdown_control_reg;
        end
        if (!addr_ok) begin
            rd_mux = 32'h0;
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg <= 32'h0;
        end else if (rd_setup) begin
            prdata_reg <= rd_mux;
        end
    end

    // Outputs
    assign prdata         = prdata_reg;
    assign remote_wake    = remote_wake_reg;
    assign wake_interrupt = wake_int_reg;
    // powerdown request; the PHY stays silent and interrupts on activity
    assign phy_energy_powerdown = energy_powerdown_control_reg;
    assign suspended      = in_susp;

    // Checks
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    property p_lan_status;
        mac_comp |=> wake_status_bits_reg[1];
    endproperty
    a_lan_status: assert property (p_lan_status) else $error("LAN status lost to clear");
    property p_ed_status;
        phy_int_s |=> wake_status_bits_reg[0];
    endproperty
    a_ed_status: assert property (p_ed_status) else $error("energy status lost to clear");
    property p_rcv_magic;
        (mac_magic_evt & mac_en_reg[`RW_SRC_MAGIC]) |=> mac_rcv_reg[`RW_RCV_MAGIC];
    endproperty
    a_rcv_magic: assert property (p_rcv_magic) else $error("magic source not recorded");
    property p_int_follow;
        (lan_int | energy_int) |=> wake_int_reg;
    endproperty
    a_int_follow: assert property (p_int_follow) else $error("wake interrupt missing");
    property p_lan_wake;
        (s_zero & lan_wake_enable_reg & wake_status_bits_reg[1] & (|mac_en_reg))
            |=> remote_wake && st_reg == rwake_pkg::RWAKE_NORMAL;
    endproperty
    a_lan_wake: assert property (p_lan_wake) else $error("LAN wake not requested");
    property p_ed_wake;
        (s_one & energy_wake_enable_reg & wake_status_bits_reg[0]) |=> remote_wake;
    endproperty
    a_ed_wake: assert property (p_ed_wake) else $error("energy wake not requested");
    sequence s_good_seen;
        s_three & ~host_resume & mac_good_frame_evt & ~(|mac_en_reg);
    endsequence
    property p_good_wake;
        s_good_seen |=> ##1 remote_wake;
    endproperty
    a_good_wake: assert property (p_good_wake) else $error("good frame wake late");
    property p_pin_wake;
        (in_susp & (|pin_event_flag_reg)) |=> remote_wake && !in_susp;
    endproperty
    a_pin_wake: assert property (p_pin_wake) else $error("pin flag did not wake");
    property p_wake_cause;
        remote_wake |-> $past(in_susp) && !in_susp;
    endproperty
    a_wake_cause: assert property (p_wake_cause) else $error("wake outside suspend");
    property p_link7;
        (link7_mode & phy_link_s & pin_wake_enable_reg[`RW_PIN7] & pin_en_path[`RW_PIN7])
            |=> pin_event_flag_reg[`RW_PIN7];
    endproperty
    a_link7: assert property (p_link7) else $error("link-up not routed to pin 7");

endmodule : rwake_top

//--- src/rwake_defines.svh
`ifndef RWAKE_DEFINES_SVH
`define RWAKE_DEFINES_SVH

// Register byte offsets
`define RW_PMR_OFF        8'h00
`define RW_MWC_OFF        8'h04
`define RW_PCFG_OFF       8'h08
`define RW_LCFG_OFF       8'h0C
`define RW_PWAKE_OFF      8'h10
`define RW_ISTS_OFF       8'h14
`define RW_CTRL_OFF       8'h18

// Power management register fields
`define RW_PMR_STAT_LSB   0
`define RW_PMR_STAT_MSB   1
`define RW_PMR_ENERGY_WAKE_ENABLE      2
`define RW_PMR_LAN_EN     3
`define RW_PMR_SUSP_LSB   4
`define RW_PMR_SUSP_MSB   5
`define RW_PMR_SUSPENDED  6
`define RW_PMR_WAKE_INT   7

// MAC wake control register fields
`define RW_MWC_EN_LSB     0
`define RW_MWC_EN_MSB     4
`define RW_MWC_RCV_LSB    5
`define RW_MWC_RCV_MSB    8

// MAC wake source order within the enable field
`define RW_SRC_UNICAST    0
`define RW_SRC_MAGIC      1
`define RW_SRC_PATTERN    2
`define RW_SRC_EXACT      3
`define RW_SRC_BCAST      4

// Received-status order
`define RW_RCV_PATTERN    0
`define RW_RCV_MAGIC      1
`define RW_RCV_EXACT      2
`define RW_RCV_BCAST      3

// Pin wake register fields
`define RW_PW_EN_LSB      0
`define RW_PW_EN_MSB      10
`define RW_PW_POL_LSB     16
`define RW_PW_POL_MSB     26
`define RW_PW_LINK7       31

// Led pin config: function select pairs then directions
`define RW_LC_FS_LSB      0
`define RW_LC_FS_MSB      5
`define RW_LC_DIR_LSB     8
`define RW_LC_DIR_MSB     10

// Control register fields
`define RW_CTRL_INT_PHY   0
`define RW_CTRL_EDPD      1

// Reset values, input function code and pin 7 index
`define RW_LOW_EN_RST     8'hFF
`define RW_LCFG_FS_RST    6'h3F
`define RW_LCFG_DIR_RST   3'h7
`define RW_FS_INPUT       2'h0
`define RW_PIN7           7

`endif

//--- src/rwake_pkg.sv
package rwake_pkg;

    // Device power state
    typedef enum logic [0:0] {
        RWAKE_NORMAL    = 1'b0,
        RWAKE_SUSPENDED = 1'b1
    } rwake_state_e;

    // Suspend select field
    typedef enum logic [1:0] {
        RWAKE_SUSP_ZERO  = 2'b00,
        RWAKE_SUSP_ONE   = 2'b01,
        RWAKE_SUSP_TWO   = 2'b10,
        RWAKE_SUSP_THREE = 2'b11
    } rwake_susp_e;

endpackage : rwake_pkg

//--- tb/rwake_host_model.sv
`timescale 1ns/1ps

// Behavioural USB host: sends suspend signaling, resumes on command
module rwake_host_model (
    // Clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // Driver commands and device wake
    input  wire logic go_suspend,
    input  wire logic go_resume,
    input  wire logic remote_wake,
    // Bus state toward the device
    output logic      usb_suspend,
    output logic      host_resume
);
    // suspend signaling last
    // Suspend stays up until the device wakes or the host resumes it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            usb_suspend <= 1'b0;
            host_resume <= 1'b0;
        end else begin
            usb_suspend <= go_suspend | (usb_suspend & ~remote_wake & ~go_resume);
            host_resume <= go_resume;
        end
    end
endmodule : rwake_host_model

//--- tb/remote_wake_detection_bench.sv
`timescale 1ns/1ps
`include "rwake_defines.svh"

module remote_wake_detection_bench;
    // Stimulus and observed signals
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic [31:0] rd;
    logic        pready;
    logic        pslverr;
    logic        err;
    logic [4:0]  mac_evt = 5'h00;
    logic        good_evt = 1'b0;
    logic        phy_int = 1'b0;
    logic        link_up = 1'b0;
    logic [10:0] pins = 11'h000;
    logic        go_susp = 1'b0;
    logic        go_res = 1'b0;
    logic        usb_suspend, host_resume, remote_wake, wake_int, edpd, suspended;
    int          failures = 0;
    int          comparisons = 0;
    int          cycles = 0;
    logic [8:0]  rcv_tab [5] = '{9'h000, 9'h040, 9'h020, 9'h080, 9'h100};

    // 20 MHz clock
    always #25 pclk = ~pclk;

    rwake_top #(.ADDR_W(8), .NPINS(11)) rwake_top_i (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .mac_unicast_evt(mac_evt[0]), .mac_magic_evt(mac_evt[1]), .mac_pattern_evt(mac_evt[2]),
        .mac_exact_dest_evt(mac_evt[3]), .mac_bcast_evt(mac_evt[4]), .mac_good_frame_evt(good_evt),
        .phy_interrupt(phy_int), .phy_link_up(link_up), .pin_level(pins),
        .usb_suspend(usb_suspend), .host_resume(host_resume), .remote_wake(remote_wake),
        .wake_interrupt(wake_int), .phy_energy_powerdown(edpd), .suspended(suspended));

    rwake_host_model rwake_host_model_i (
        .pclk(pclk), .presetn(presetn), .go_suspend(go_susp), .go_resume(go_res),
        .remote_wake(remote_wake), .usb_suspend(usb_suspend), .host_resume(host_resume));

    task automatic stop_test();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : stop_test

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // One APB transfer; the request holds until pready is seen high
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : xfer

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask : wr

    task automatic rdc(input string s, input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m);
        xfer(1'b0, a, 32'h0);
        chk(s, exp, rd & m);
    endtask : rdc

    task automatic sleep();
        @(posedge pclk);
        go_susp <= 1'b1;
        @(posedge pclk);
        go_susp <= 1'b0;
        repeat (3) @(posedge pclk);
        chk("suspended", 32'h1, {31'h0, suspended});
    endtask : sleep

    // Looks for the one-cycle wake pulse over a window longer than the sync delay
    task automatic wake(input logic exp);
        logic seen;
        seen = 1'b0;
        repeat (12) begin
            @(posedge pclk);
            if (remote_wake === 1'b1) seen = 1'b1;
        end
        chk("remote_wake", {31'h0, exp}, {31'h0, seen});
    endtask : wake

    // Hang guard
    always @(posedge pclk) begin
        cycles = cycles + 1;
        if (cycles == 20000) begin
            failures = failures + 1;
            stop_test();
        end
    end

    // Test sequence
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        rdc("pmr", `RW_PMR_OFF, 32'h20, 32'hFF);
        rdc("pcfg", `RW_PCFG_OFF, 32'hFF, 32'hFF);
        rdc("lcfg", `RW_LCFG_OFF, 32'h73F, 32'h7FF);
        rdc("unmapped", 8'h1C, 32'h0, 32'hFFFFFFFF);
        chk("pslverr", 32'h1, {31'h0, err});
        for (int i = 0; i < 5; i++) begin
            wr(`RW_MWC_OFF, 32'h1E0 | (32'h1 << i));
            wr(`RW_PMR_OFF, 32'h0B);
            sleep();
            mac_evt[i] <= 1'b1;
            @(posedge pclk);
            mac_evt[i] <= 1'b0;
            wake(1'b1);
            rdc("pmr", `RW_PMR_OFF, 32'h0A, 32'h7F);
            rdc("mwc", `RW_MWC_OFF, (32'h1 << i) | {23'h0, rcv_tab[i]}, 32'h1FF);
        end
        wr(`RW_MWC_OFF, 32'h1E0);
        wr(`RW_PMR_OFF, 32'h07);
        sleep();
        phy_int <= 1'b1;
        wake(1'b0);
        chk("wake_int", 32'h1, {31'h0, wake_int});
        wr(`RW_PMR_OFF, 32'h05);
        rdc("pmr", `RW_PMR_OFF, 32'h45, 32'h7F);
        phy_int <= 1'b0;
        @(posedge pclk);
        go_res <= 1'b1;
        @(posedge pclk);
        go_res <= 1'b0;
        repeat (3) @(posedge pclk);
        chk("resumed", 32'h0, {31'h0, suspended});
        wr(`RW_PMR_OFF, 32'h17);
        sleep();
        phy_int <= 1'b1;
        wake(1'b1);
        phy_int <= 1'b0;
        wr(`RW_PMR_OFF, 32'h33);
        sleep();
        good_evt <= 1'b1;
        @(posedge pclk);
        good_evt <= 1'b0;
        wake(1'b1);
        wr(`RW_CTRL_OFF, 32'h2);
        wr(`RW_PCFG_OFF, 32'hFE);
        chk("edpd", 32'h1, {31'h0, edpd});
        wr(`RW_LCFG_OFF, 32'h0);
        wr(`RW_PWAKE_OFF, 32'h0201_0201);
        wr(`RW_PMR_OFF, 32'h23);
        sleep();
        pins[0] <= 1'b1;
        wake(1'b0);
        pins[9] <= 1'b1;
        wake(1'b1);
        rdc("ists", `RW_ISTS_OFF, 32'h200, 32'h7FF);
        // Link-up routed onto pin 7 in state zero; stale flags cleared first
        pins[9] <= 1'b0;
        wr(`RW_CTRL_OFF, 32'h1);
        wr(`RW_PCFG_OFF, 32'h7F);
        chk("edpd", 32'h0, {31'h0, edpd});
        wr(`RW_PWAKE_OFF, 32'h8000_0080);
        wr(`RW_ISTS_OFF, 32'h7FF);
        wr(`RW_PMR_OFF, 32'h03);
        sleep();
        link_up <= 1'b1;
        wake(1'b1);
        rdc("ists", `RW_ISTS_OFF, 32'h080, 32'h7FF);
        stop_test();
    end
endmodule : remote_wake_detection_bench
